//--- hw/flash_sig_check.sv
// Reads the four signature bytes from flash and compares them in order.
// Flash answers a held read request with a one-cycle valid and data.
`timescale 1ns/1ns
`include "hub_boot_map.svh"
module flash_sig_check
  import hub_boot_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  sig_check_if.chk sig
);

  chk_regs_t r;
  chk_regs_t next_r;

  function automatic logic [7:0] sig_byte(input logic [1:0] idx);
    case (idx)
      2'h0: sig_byte = `SIG_BYTE0;
      2'h1: sig_byte = `SIG_BYTE1;
      2'h2: sig_byte = `SIG_BYTE2;
      default: sig_byte = `SIG_BYTE3;
    endcase
  endfunction

  always_comb
  begin
    next_r = r;
    case (r.st)
      CK_IDLE:
      begin
        next_r.done = 1'b0;
        if (sig.start)
        begin
          next_r.idx      = 2'h0;
          next_r.ok       = 1'b1;
          next_r.match    = 1'b0;
          next_r.addr     = `SIG_BASE_ADDR;
          next_r.req      = 1'b1;
          next_r.wait_cnt = 8'h00;
          next_r.st       = CK_REQ;
        end
      end
      CK_REQ:
      begin
        if (sig.rd_valid)
        begin
          next_r.req = 1'b0;
          next_r.ok  = r.ok & (sig.rd_data == sig_byte(r.idx));
          if (r.idx == `SIG_LAST_IDX)
          begin
            next_r.match = r.ok & (sig.rd_data == sig_byte(r.idx));
            next_r.st    = CK_DONE;
          end
          else
          begin
            next_r.idx  = r.idx + 2'h1;
            next_r.addr = r.addr + 16'h0001;
            next_r.st   = CK_NEXT;
          end
        end
        else if (r.wait_cnt == `FLASH_WAIT_CYC)
        begin
          // No flash answering counts as no signature
          next_r.req   = 1'b0;
          next_r.match = 1'b0;
          next_r.st    = CK_DONE;
        end
        else
        begin
          next_r.wait_cnt = r.wait_cnt + 8'h01;
        end
      end
      CK_NEXT:
      begin
        next_r.req      = 1'b1;
        next_r.wait_cnt = 8'h00;
        next_r.st       = CK_REQ;
      end
      CK_DONE:
      begin
        next_r.done = 1'b1;
        if (!sig.start)
        begin
          next_r.done = 1'b0;
          next_r.st   = CK_IDLE;
        end
      end
      default:
      begin
        next_r.st = CK_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      r <= '{st: CK_IDLE, idx: 2'h0, ok: 1'b0, match: 1'b0, done: 1'b0, req: 1'b0,
             addr: 16'h0000, wait_cnt: 8'h00};
    end
    else
    begin
      r <= next_r;
    end
  end

  assign sig.done    = r.done;
  assign sig.match   = r.match;
  assign sig.rd_req  = r.req;
  assign sig.rd_addr = r.addr;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  property p_byte_mismatch_kills;
    (r.st == CK_REQ && sig.rd_valid && sig.rd_data != sig_byte(r.idx)) |=> !r.ok;
  endproperty
  a_byte_mismatch_kills: assert property (p_byte_mismatch_kills)
    else $error("signature byte mismatch not recorded");

  property p_match_needs_all;
    (r.st == CK_REQ && !r.ok) |=> !r.match;
  endproperty
  a_match_needs_all: assert property (p_match_needs_all)
    else $error("match declared after an earlier byte differed");

  property p_sig_addr_range;
    sig.rd_req |-> (sig.rd_addr >= `SIG_BASE_ADDR && sig.rd_addr <= 16'hfffd);
  endproperty
  a_sig_addr_range: assert property (p_sig_addr_range)
    else $error("signature read outside 0xfffa..0xfffd");

endmodule

//--- hw/hub_boot_config_sequencer.sv
// Boot and configuration sequencer of the hub: flash signature check,
// strap read, SoC configuration over SMBus, OTP merge, charger detect,
// connect and normal mode. All inputs are synchronous to core_clk.
`timescale 1ns/1ns
`include "hub_boot_map.svh"
module hub_boot_config_sequencer
  import hub_boot_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        spi_strap,
  input  wire logic        cfg_strap_smbus,
  input  wire logic        smbus_data_pin,
  input  wire logic        smbus_clock_pin,
  output wire logic        flash_rd_req,
  output wire logic [15:0] flash_rd_addr,
  input  wire logic        flash_rd_valid,
  input  wire logic [7:0]  flash_rd_data,
  input  wire logic        smbus_wr_valid,
  input  wire logic [7:0]  smbus_wr_addr,
  input  wire logic        bc_enable,
  input  wire logic        vbus_sense,
  input  wire logic        charger_detect_done,
  input  wire logic        upstream_link_up,
  input  wire logic        mode_change,
  output wire logic        ext_mem_en,
  output wire logic        rom_boot,
  output wire logic [15:0] fetch_addr,
  output wire logic        smbus_slave_en,
  output wire logic        smbus_reg_access_en,
  output wire logic        otp_smbus_allow,
  output wire logic        otp_usb_allow,
  output wire logic        charger_detect_start,
  output wire logic        usb_connect,
  output wire logic        normal_mode,
  output wire logic [9:0]  boot_state
);

  seq_regs_t r;
  seq_regs_t next_r;

  sig_check_if sig ();

  flash_sig_check u_sig_check
  (
    .core_clk (core_clk),
    .rst      (rst),
    .sig      (sig.chk)
  );

  assign sig.start    = r.sig_start;
  assign sig.rd_valid = flash_rd_valid;
  assign sig.rd_data  = flash_rd_data;
  assign flash_rd_req  = sig.rd_req;
  assign flash_rd_addr = sig.rd_addr;

  function automatic logic pullups_seen(input logic dat, input logic clk);
    pullups_seen = dat & clk;
  endfunction

  function automatic logic cfg_done_write(input logic vld, input logic [7:0] addr);
    cfg_done_write = vld & (addr == `CFG_DONE_REG);
  endfunction

  always_comb
  begin
    next_r = r;
    case (r.st)
      ST_STANDBY:
      begin
        next_r.ext_mem_en     = 1'b0;
        next_r.smbus_slave_en = 1'b0;
        next_r.usb_connect    = 1'b0;
        next_r.sig_start      = 1'b0;
        next_r.fetch_addr     = `ROM_FETCH_ADDR;
        next_r.st             = ST_SPI_INIT;
        if (spi_strap)
        begin
          next_r.sig_start = 1'b1;
        end
      end
      ST_SPI_INIT:
      begin
        if (!r.sig_start)
        begin
          // Not strapped for SPI: internal ROM
          next_r.ext_mem_en = 1'b0;
          next_r.fetch_addr = `ROM_FETCH_ADDR;
          next_r.st         = ST_CFG_RD;
        end
        else if (sig.done)
        begin
          next_r.sig_start  = 1'b0;
          next_r.ext_mem_en = sig.match;
          next_r.fetch_addr = sig.match ? `EXT_FETCH_ADDR : `ROM_FETCH_ADDR;
          next_r.st         = ST_CFG_RD;
        end
      end
      ST_CFG_RD:
      begin
        next_r.st = ST_STRAP;
      end
      ST_STRAP:
      begin
        if (cfg_strap_smbus && pullups_seen(smbus_data_pin, smbus_clock_pin))
        begin
          next_r.smbus_slave_en = 1'b1;
          next_r.st             = ST_SOC_CFG;
        end
        else
        begin
          next_r.st = ST_OTP_CFG;
        end
      end
      ST_SOC_CFG:
      begin
        // Waits with no limit for the end-of-configuration write
        if (cfg_done_write(smbus_wr_valid, smbus_wr_addr))
        begin
          next_r.st = ST_OTP_CFG;
        end
      end
      ST_OTP_CFG:
      begin
        next_r.st = ST_IDLE;
      end
      ST_IDLE:
      begin
        if (vbus_sense)
        begin
          next_r.st = bc_enable ? ST_CHARGER_DETECT : ST_CONNECT;
        end
      end
      ST_CHARGER_DETECT:
      begin
        if (!vbus_sense)
        begin
          next_r.st = ST_IDLE;
        end
        else if (charger_detect_done)
        begin
          next_r.st = ST_CONNECT;
        end
      end
      ST_CONNECT:
      begin
        next_r.usb_connect = vbus_sense;
        if (!vbus_sense)
        begin
          next_r.st = ST_IDLE;
        end
        else if (upstream_link_up)
        begin
          next_r.st = ST_NORMAL;
        end
      end
      ST_NORMAL:
      begin
        next_r.usb_connect = 1'b1;
        if (mode_change)
        begin
          next_r.usb_connect = 1'b0;
          next_r.st          = ST_STANDBY;
        end
      end
      default:
      begin
        next_r.st = ST_STANDBY;
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      r <= '{st: ST_STANDBY, sig_start: 1'b0, ext_mem_en: 1'b0, smbus_slave_en: 1'b0,
             usb_connect: 1'b0, fetch_addr: `ROM_FETCH_ADDR};
    end
    else
    begin
      r <= next_r;
    end
  end

  assign ext_mem_en           = r.ext_mem_en;
  assign rom_boot             = !r.ext_mem_en;
  assign fetch_addr           = r.fetch_addr;
  assign smbus_slave_en       = r.smbus_slave_en;
  assign smbus_reg_access_en  = r.smbus_slave_en;
  assign otp_smbus_allow      = r.smbus_slave_en && (r.st == ST_SOC_CFG);
  assign otp_usb_allow        = (r.st == ST_NORMAL);
  assign charger_detect_start = (r.st == ST_CHARGER_DETECT);
  assign usb_connect          = r.usb_connect;
  assign normal_mode          = (r.st == ST_NORMAL);
  assign boot_state           = r.st;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  property p_standby_to_init;
    (r.st == ST_STANDBY && !rst) |=> (r.st == ST_SPI_INIT);
  endproperty
  a_standby_to_init: assert property (p_standby_to_init)
    else $error("standby did not move to spi init");

  property p_connect_after_charger_detect;
    (r.st == ST_CHARGER_DETECT && !charger_detect_done) |=> (r.st != ST_CONNECT);
  endproperty
  a_connect_after_charger_detect: assert property (p_connect_after_charger_detect)
    else $error("connect entered before charger detection ended");

  property p_vbus_connects;
    (r.st == ST_CONNECT && vbus_sense) |=> r.usb_connect;
  endproperty
  a_vbus_connects: assert property (p_vbus_connects)
    else $error("vbus high in connect stage but no usb connect");

  property p_connect_holds;
    (r.st == ST_CONNECT && vbus_sense && !upstream_link_up) |=> (r.st == ST_CONNECT);
  endproperty
  a_connect_holds: assert property (p_connect_holds)
    else $error("connect stage left while vbus still high");

  property p_normal_holds;
    (r.st == ST_NORMAL && !mode_change) |=> (r.st == ST_NORMAL) && usb_connect;
  endproperty
  a_normal_holds: assert property (p_normal_holds)
    else $error("normal mode left without a mode change");

  property p_sig_match_ext;
    (r.st == ST_SPI_INIT && r.sig_start && sig.done && sig.match)
      |=> ext_mem_en && fetch_addr == `EXT_FETCH_ADDR && r.st == ST_CFG_RD;
  endproperty
  a_sig_match_ext: assert property (p_sig_match_ext)
    else $error("matching signature did not enable external fetch");

  property p_sig_miss_rom;
    (r.st == ST_SPI_INIT && (!r.sig_start || (sig.done && !sig.match)))
      |=> rom_boot ##1 (r.st == ST_STRAP && rom_boot);
  endproperty
  a_sig_miss_rom: assert property (p_sig_miss_rom)
    else $error("missing signature did not boot from rom");

  property p_smbus_needs_pullups;
    $rose(smbus_slave_en) |-> $past(cfg_strap_smbus && smbus_data_pin && smbus_clock_pin)
      && (r.st == ST_SOC_CFG);
  endproperty
  a_smbus_needs_pullups: assert property (p_smbus_needs_pullups)
    else $error("smbus slave enabled without strap and pull-ups");

  property p_strap_branch;
    (r.st == ST_STRAP) |=>
      (r.st == (($past(cfg_strap_smbus) && $past(smbus_data_pin) && $past(smbus_clock_pin))
                ? ST_SOC_CFG : ST_OTP_CFG));
  endproperty
  a_strap_branch: assert property (p_strap_branch)
    else $error("strap stage took the wrong branch");

  property p_soc_cfg_waits;
    (r.st == ST_SOC_CFG && !cfg_done_write(smbus_wr_valid, smbus_wr_addr))
      |=> (r.st == ST_SOC_CFG) && otp_smbus_allow;
  endproperty
  a_soc_cfg_waits: assert property (p_soc_cfg_waits)
    else $error("soc configuration ended without the 0xff write");

  property p_otp_windows;
    otp_usb_allow |-> (normal_mode && !otp_smbus_allow);
  endproperty
  a_otp_windows: assert property (p_otp_windows)
    else $error("otp access window open in the wrong stage");

  property p_reg_access_smbus;
    smbus_reg_access_en |-> smbus_slave_en;
  endproperty
  a_reg_access_smbus: assert property (p_reg_access_smbus)
    else $error("register access open without smbus slave");

endmodule

//--- hw/hub_boot_map.svh
// Constants for the hub boot and configuration sequencer.
// Assumes a 10 MHz core clock; included by bare name from the design files.
`ifndef HUB_BOOT_MAP_SVH
`define HUB_BOOT_MAP_SVH

`define SIG_BASE_ADDR   16'hfffa
`define SIG_BYTE0       8'h32
`define SIG_BYTE1       8'h44
`define SIG_BYTE2       8'h46
`define SIG_BYTE3       8'h55
`define SIG_LAST_IDX    2'h3
`define EXT_FETCH_ADDR  16'h0000
`define ROM_FETCH_ADDR  16'h0000
`define CFG_DONE_REG    8'hff
`define FLASH_WAIT_CYC  8'hff

`endif

//--- hw/hub_boot_pkg.sv
// Types for the hub boot and configuration sequencer.
// Constants live in hub_boot_map.svh.
package hub_boot_pkg;

  typedef enum logic [9:0]
  {
    ST_STANDBY        = 10'h001,
    ST_SPI_INIT       = 10'h002,
    ST_CFG_RD         = 10'h004,
    ST_STRAP          = 10'h008,
    ST_SOC_CFG        = 10'h010,
    ST_OTP_CFG        = 10'h020,
    ST_IDLE           = 10'h040,
    ST_CHARGER_DETECT = 10'h080,
    ST_CONNECT        = 10'h100,
    ST_NORMAL         = 10'h200
  } boot_state_t;

  typedef enum logic [3:0]
  {
    CK_IDLE = 4'h1,
    CK_REQ  = 4'h2,
    CK_NEXT = 4'h4,
    CK_DONE = 4'h8
  } chk_state_t;

  typedef struct packed
  {
    boot_state_t st;
    logic        sig_start;
    logic        ext_mem_en;
    logic        smbus_slave_en;
    logic        usb_connect;
    logic [15:0] fetch_addr;
  } seq_regs_t;

  typedef struct packed
  {
    chk_state_t  st;
    logic [1:0]  idx;
    logic        ok;
    logic        match;
    logic        done;
    logic        req;
    logic [15:0] addr;
    logic [7:0]  wait_cnt;
  } chk_regs_t;

endpackage

//--- hw/sig_check_if.sv
// Link between the boot sequencer and the flash signature checker.
// Both ends run on the same core clock.
`timescale 1ns/1ns
interface sig_check_if;
  logic        start;
  logic        done;
  logic        match;
  logic        rd_req;
  logic [15:0] rd_addr;
  logic        rd_valid;
  logic [7:0]  rd_data;

  modport seq
  (
    output start,
    output rd_valid,
    output rd_data,
    input  done,
    input  match,
    input  rd_req,
    input  rd_addr
  );

  modport chk
  (
    input  start,
    input  rd_valid,
    input  rd_data,
    output done,
    output match,
    output rd_req,
    output rd_addr
  );
endinterface

//--- tb/flash_partner.sv
// Behavioural serial flash behind the sequencer's byte-read port.
// Assumes a read request is held until answered; the answer is a one-cycle valid.
`timescale 1ns/1ns
module flash_partner
(
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        rd_req,
  input  wire logic [15:0] rd_addr,
  input  wire logic [7:0]  delay,
  input  wire logic        mute,
  input  wire logic [2:0]  bad_idx,
  output logic             rd_valid,
  output logic [7:0]       rd_data
);
  logic [7:0] cnt;
  logic [1:0] idx;

  assign idx = 2'(rd_addr - 16'hfffa);

  // Signature text held from the base of the signature area, byte 0 at 0xfffa
  function automatic logic [7:0] sig_byte(input logic [1:0] i);
    case (i)
      2'h0: return 8'h32;
      2'h1: return 8'h44;
      2'h2: return 8'h46;
      default: return 8'h55;
    endcase
  endfunction

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      rd_valid <= 1'b0;
      rd_data  <= 8'h00;
      cnt      <= 8'h00;
    end
    else
    begin
      rd_valid <= 1'b0;
      // Released data line wiggles so stale bytes never look valid
      rd_data  <= ~rd_data;
      if (rd_req && !rd_valid && !mute)
      begin
        if (cnt >= delay)
        begin
          rd_valid <= 1'b1;
          rd_data  <= sig_byte(idx) ^ ((3'(idx) == bad_idx) ? 8'h01 : 8'h00);
          cnt      <= 8'h00;
        end
        else
          cnt <= cnt + 8'h01;
      end
      else
        cnt <= 8'h00;
    end
  end
endmodule

//--- tb/testbench.sv
// Self-checking bench for the hub boot and configuration sequencer.
// Assumes the flash partner model; the SMBus host is driven by the bench.
`timescale 1ns/1ns
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin miscompares++; \
  $display("MISMATCH at %0t: got %h expected %h", $time, (a), (b)); end end
module testbench;
  import hub_boot_pkg::*;
  logic core_clk = 1'b0, rst = 1'b1, spi_strap = 1'b0, cfg_strap_smbus = 1'b0;
  logic smbus_data_pin = 1'b0, smbus_clock_pin = 1'b0, flash_rd_req, flash_rd_valid;
  logic [15:0] flash_rd_addr, fetch_addr;
  logic [7:0]  flash_rd_data, smbus_wr_addr = 8'h00, delay = 8'h00;
  logic smbus_wr_valid = 1'b0, bc_enable = 1'b0, vbus_sense = 1'b0, mute = 1'b0;
  logic charger_detect_done = 1'b0, upstream_link_up = 1'b0, mode_change = 1'b0;
  logic ext_mem_en, rom_boot, smbus_slave_en, smbus_reg_access_en, otp_smbus_allow;
  logic otp_usb_allow, charger_detect_start, usb_connect, normal_mode;
  logic [9:0]  boot_state;
  logic [2:0]  bad_idx = 3'h4;
  logic [15:0] addr_q[$];
  int          miscompares = 0, cmp_count = 0;

  always #50 core_clk = ~core_clk;

  hub_boot_config_sequencer hub_boot_config_sequencer_i (.core_clk(core_clk), .rst(rst),
    .spi_strap(spi_strap), .cfg_strap_smbus(cfg_strap_smbus),
    .smbus_data_pin(smbus_data_pin), .smbus_clock_pin(smbus_clock_pin),
    .flash_rd_req(flash_rd_req), .flash_rd_addr(flash_rd_addr),
    .flash_rd_valid(flash_rd_valid), .flash_rd_data(flash_rd_data),
    .smbus_wr_valid(smbus_wr_valid), .smbus_wr_addr(smbus_wr_addr), .bc_enable(bc_enable),
    .vbus_sense(vbus_sense), .charger_detect_done(charger_detect_done),
    .upstream_link_up(upstream_link_up), .mode_change(mode_change),
    .ext_mem_en(ext_mem_en), .rom_boot(rom_boot), .fetch_addr(fetch_addr),
    .smbus_slave_en(smbus_slave_en), .smbus_reg_access_en(smbus_reg_access_en),
    .otp_smbus_allow(otp_smbus_allow), .otp_usb_allow(otp_usb_allow),
    .charger_detect_start(charger_detect_start), .usb_connect(usb_connect),
    .normal_mode(normal_mode), .boot_state(boot_state));

  flash_partner flash_partner_i (.core_clk(core_clk), .rst(rst), .rd_req(flash_rd_req),
    .rd_addr(flash_rd_addr), .delay(delay), .mute(mute), .bad_idx(bad_idx),
    .rd_valid(flash_rd_valid), .rd_data(flash_rd_data));

  // Addresses of every answered flash read
  always @(posedge core_clk)
    if (flash_rd_req && flash_rd_valid)
      addr_q.push_back(flash_rd_addr);

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic wait_state(input boot_state_t s, input int bound);
    int i;
    for (i = 0; i < bound; i++)
    begin
      @(posedge core_clk);
      #1;
      if (boot_state === s)
        break;
    end
    if (i == bound)
    begin
      miscompares++;
      $display("MISMATCH at %0t: state %h not reached", $time, s);
      complete_run();
    end
  endtask

  task automatic boot(input logic spi, input logic cfg, input logic dat, input logic clk);
    @(posedge core_clk);
    rst             <= 1'b1;
    spi_strap       <= spi;
    cfg_strap_smbus <= cfg;
    smbus_data_pin  <= dat;
    smbus_clock_pin <= clk;
    vbus_sense      <= 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
    `CHK(boot_state, ST_STANDBY)
    `CHK(rom_boot, 1'b1)
    addr_q.delete();
    @(posedge core_clk);
    rst <= 1'b0;
  endtask

  task automatic t_spi_good();
    delay <= 8'h03;
    boot(1'b1, 1'b0, 1'b1, 1'b1);
    wait_state(ST_CFG_RD, 100);
    `CHK(ext_mem_en, 1'b1)
    `CHK(rom_boot, 1'b0)
    `CHK(fetch_addr, 16'h0000)
    `CHK(addr_q.size(), 4)
    foreach (addr_q[i])
      `CHK(addr_q[i], 16'hfffa + 16'(i))
    wait_state(ST_IDLE, 20);
    `CHK(smbus_slave_en, 1'b0)
    @(posedge core_clk);
    vbus_sense <= 1'b1;
    wait_state(ST_CONNECT, 5);
    @(posedge core_clk);
    upstream_link_up <= 1'b1;
    #1;
    `CHK(usb_connect, 1'b1)
    wait_state(ST_NORMAL, 5);
    `CHK(normal_mode, 1'b1)
    `CHK(otp_usb_allow, 1'b1)
    `CHK(otp_smbus_allow, 1'b0)
    repeat (30) @(posedge core_clk);
    mode_change <= 1'b1;
    #1;
    `CHK(boot_state, ST_NORMAL)
    @(posedge core_clk);
    mode_change      <= 1'b0;
    upstream_link_up <= 1'b0;
    delay            <= 8'h00;
    #1;
    `CHK(normal_mode, 1'b0)
  endtask

  task automatic t_bad_sig();
    for (int k = 0; k < 4; k++)
    begin
      boot(1'b1, 1'b0, 1'b0, 1'b0);
      bad_idx <= 3'(k);
      wait_state(ST_CFG_RD, 100);
      `CHK(ext_mem_en, 1'b0)
      `CHK(rom_boot, 1'b1)
    end
    boot(1'b1, 1'b0, 1'b0, 1'b0);
    bad_idx <= 3'h4;
    mute    <= 1'b1;
    wait_state(ST_CFG_RD, 600);
    `CHK(ext_mem_en, 1'b0)
    boot(1'b0, 1'b0, 1'b0, 1'b0);
    mute <= 1'b0;
    wait_state(ST_CFG_RD, 20);
    `CHK(addr_q.size(), 0)
    `CHK(rom_boot, 1'b1)
  endtask

  task automatic t_smbus();
    for (int k = 0; k < 7; k++)
    begin
      boot(1'b0, k[2], k[1], k[0]);
      wait_state(ST_IDLE, 40);
      `CHK(smbus_slave_en, 1'b0)
    end
    boot(1'b0, 1'b1, 1'b1, 1'b1);
    wait_state(ST_SOC_CFG, 40);
    `CHK(smbus_slave_en, 1'b1)
    `CHK(smbus_reg_access_en, 1'b1)
    `CHK(otp_smbus_allow, 1'b1)
    `CHK(otp_usb_allow, 1'b0)
    @(posedge core_clk);
    smbus_wr_valid <= 1'b1;
    smbus_wr_addr  <= 8'hfe;
    @(posedge core_clk);
    smbus_wr_valid <= 1'b0;
    repeat (60) @(posedge core_clk);
    smbus_wr_valid <= 1'b1;
    smbus_wr_addr  <= 8'hff;
    #1;
    `CHK(boot_state, ST_SOC_CFG)
    @(posedge core_clk);
    smbus_wr_valid <= 1'b0;
    #1;
    `CHK(boot_state, ST_OTP_CFG)
    `CHK(otp_smbus_allow, 1'b0)
    `CHK(smbus_slave_en, 1'b1)
  endtask

  task automatic t_connect();
    boot(1'b0, 1'b0, 1'b0, 1'b0);
    wait_state(ST_IDLE, 40);
    @(posedge core_clk);
    bc_enable  <= 1'b1;
    vbus_sense <= 1'b1;
    wait_state(ST_CHARGER_DETECT, 5);
    repeat (20) @(posedge core_clk);
    charger_detect_done <= 1'b1;
    #1;
    `CHK(charger_detect_start, 1'b1)
    `CHK(usb_connect, 1'b0)
    wait_state(ST_CONNECT, 3);
    repeat (40) @(posedge core_clk);
    charger_detect_done <= 1'b0;
    vbus_sense          <= 1'b0;
    #1;
    `CHK(boot_state, ST_CONNECT)
    `CHK(usb_connect, 1'b1)
    wait_state(ST_IDLE, 3);
    `CHK(usb_connect, 1'b0)
    @(posedge core_clk);
    bc_enable  <= 1'b0;
    vbus_sense <= 1'b1;
    wait_state(ST_CONNECT, 5);
    @(posedge core_clk);
    rst <= 1'b1;
    #1;
    `CHK(boot_state, ST_STANDBY)
    `CHK(usb_connect, 1'b0)
    @(posedge core_clk);
    rst <= 1'b0;
  endtask

  initial
  begin
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    t_spi_good();
    t_bad_sig();
    t_smbus();
    t_connect();
    repeat (5) @(posedge core_clk);
    complete_run();
  end
endmodule
